/* File: wdru_pkg.sv */
// constants, field layouts and carrier types shared by the watchdog reset unit
package wdru_pkg;

  // bus geometry
  localparam int          AXI_ADDR_W    = 20;                 // byte address width, covers 4 * 16-bit index
  localparam int          AXI_DATA_W    = 32;                 // data width of the register bus

  // register indices; byte address is four times the index
  localparam logic [15:0] CTRL_INDEX    = 16'hfe79;           // watchdog_control
  localparam logic [15:0] CLEAR_INDEX   = 16'hfe7a;           // immediate-move clear port
  localparam logic [15:0] STATUS_INDEX  = 16'hfe7b;           // counter and reset status, read only
  localparam logic [19:0] CTRL_ADDR     = {2'b00, CTRL_INDEX, 2'b00};
  localparam logic [19:0] CLEAR_ADDR    = {2'b00, CLEAR_INDEX, 2'b00};
  localparam logic [19:0] STATUS_ADDR   = {2'b00, STATUS_INDEX, 2'b00};

  // watchdog_control field positions
  localparam int          FLAG_BIT      = 7;                  // dog_reset_flag
  localparam int          CLKSEL_BIT    = 6;                  // dog_clock_select
  localparam int          RUN_BIT       = 5;                  // dog_run_bit
  localparam int          OPT_HI_BIT    = 4;                  // standby_option_hi
  localparam int          OPT_LO_BIT    = 3;                  // standby_option_lo
  localparam int          SEL_HI_BIT    = 2;                  // overflow_select_2
  localparam int          SEL_LO_BIT    = 0;                  // overflow_select_0

  // status register field positions
  localparam int          STAT_CNT_LO   = 0;                  // counter value, 17 bits
  localparam int          STAT_RST_BIT  = 24;                 // system reset in progress
  localparam int          STAT_CAUSE_BIT = 25;                // last reset came from the watchdog

  // reset values and codes
  localparam logic [7:0]  CTRL_RESET    = 8'h00;              // control after pin or power reset
  localparam logic [7:0]  CLEAR_CODE    = 8'h55;              // immediate value that clears the counter
  localparam int          COUNT_W       = 17;                 // watchdog_counter width
  localparam logic [16:0] BASE_COUNT    = 17'h0_0400;         // count for select code 000
  localparam logic [16:0] COUNT_ONE     = 17'h0_0001;
  localparam logic [16:0] COUNT_ZERO    = 17'h0_0000;
  localparam logic [15:0] PC_RESET      = 16'h0000;           // program counter after reset
  localparam logic [15:0] SP_RESET      = 16'h0000;           // stack pointer after reset

  // standby option encodings
  localparam logic [1:0]  OPT_SUSPEND   = 2'b01;              // stop the watchdog on standby entry
  localparam logic [1:0]  OPT_RETAIN    = 2'b10;              // freeze count during standby

  // reset stretch
  localparam int          HOLD_W        = 3;
  localparam logic [2:0]  RESET_HOLD_CYCLES = 3'h4;           // system clock cycles of internal reset
  localparam logic [2:0]  HOLD_ONE      = 3'h1;
  localparam logic [2:0]  HOLD_ZERO     = 3'h0;

  // bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // reset sequencer states
  typedef enum logic [1:0] {
    SEQ_RUN   = 2'b01,                                        // normal operation
    SEQ_RESET = 2'b10                                         // internal reset asserted
  } wdru_seq_type;

  // reset consequences driven to the rest of the chip
  typedef struct packed {
    logic        reset_n;                                     // synchronous system reset, low active
    logic        medium_rc_select;                            // force system clock to medium-speed rc
    logic        port_input_mode;                             // force port pins to input
    logic        pullup_off;                                  // force port pull-ups off
    logic        exit_to_reset;                               // standby left through reset
    logic [15:0] pc_init;                                     // program counter load value
    logic [15:0] sp_init;                                     // stack pointer load value
  } wdru_sysrst_type;

  // whole state of the unit
  typedef struct packed {
    logic [7:0]  ctrl;                                        // watchdog_control
    logic [16:0] count;                                       // watchdog_counter
    wdru_seq_type seq;                                        // reset sequencer
    logic [2:0]  hold;                                        // reset stretch counter
    logic        wdog_pulse;                                  // one-cycle watchdog reset request
    logic        standby_prev;                                // standby level, previous cycle
    logic        standby_at_reset;                            // reset hit during standby
    logic        cause_wdog;                                  // last reset cause
    logic        aw_have;                                     // write address held
    logic [19:0] awaddr;
    logic        w_have;                                      // write data held
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } wdru_state_type;

endpackage : wdru_pkg

/* File: wdru_watchdog_reset_unit.sv */
// watchdog timer with reset generation and reset-time initialisation outputs
//
// Notes on behaviour
// - 17-bit counter counts selected slow clock ticks
// - overflow when count matches selected limit
// - select codes map 1024 up to 131072
// - overflow resets, clears run, sets flag
// - pin or power reset loads 00H
// - writes ignored while running, reads allowed
// - only immediate 55H move clears counter
// - counter zero whenever run bit clear
// - rc runs for watchdog or start bit
// - select 0 is rc, 1 subclock
// - rc kept on independent of system clock
// - lost subclock while running forces reset
// - three standby behaviours supported
// - option 00/11 continue, 01 suspend, 10 retain
// - option 2 in standby halts counter
// - writing run 1 starts; writing 0 is locked out while running
// - flag cleared by pin reset, set, writable
// - all resets leave synchronous to aclk
// - pc and sp zero, medium rc selected
// - data ram never touched by reset
// - standby left through reset goes reset
// - ports input, pull-ups off during reset
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module wdru_watchdog_reset_unit #(
  parameter logic [2:0] HOLD_CYCLES = wdru_pkg::RESET_HOLD_CYCLES  // length of internal reset
) (
  input  wire logic                         aclk,             // system clock
  input  wire logic                         aresetn,          // power-on reset, low active
  // axi4-lite slave
  input  wire logic [wdru_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output      logic                         s_axi_awready,
  input  wire logic [wdru_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output      logic                         s_axi_wready,
  output      logic [1:0]                   s_axi_bresp,
  output      logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [wdru_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output      logic                         s_axi_arready,
  output      logic [wdru_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]                   s_axi_rresp,
  output      logic                         s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // clock sources and oscillator state
  input  wire logic                         rc_tick,          // one pulse per low-speed rc period
  input  wire logic                         sub_tick,         // one pulse per subclock period
  input  wire logic                         subclock_oscillator_on, // subclock enabled by software
  input  wire logic                         slow_rc_start_bit, // rc start from oscillator_control
  output      logic                         slow_rc_enable,   // low-speed rc oscillator run request
  // cpu standby and reset sources
  input  wire logic                         standby_active,   // cpu in any standby mode
  input  wire logic                         hold_mode,        // cpu in hold mode
  input  wire logic                         external_clear_pin_n, // reset pin level, low active
  input  wire logic                         low_voltage_clear, // power-on or low-voltage reset
  // reset consequences
  output      logic                         watchdog_reset,   // one-cycle watchdog reset request
  output      wdru_pkg::wdru_sysrst_type    sysrst            // reset state to the chip
);
  import wdru_pkg::*;

  // reset value of the whole state; system reset is held after power-on
  localparam wdru_state_type ST_RESET = '{
    ctrl: CTRL_RESET, count: COUNT_ZERO, seq: SEQ_RESET, hold: HOLD_CYCLES - HOLD_ONE,
    wdog_pulse: 1'b0, standby_prev: 1'b0, standby_at_reset: 1'b0, cause_wdog: 1'b0,
    aw_have: 1'b0, awaddr: '0, w_have: 1'b0, wdata: '0, wstrb: '0,
    bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY
  };

  wdru_state_type st_r;                                       // registered state
  wdru_state_type st_nxt;                                     // next state

  logic           run;                                        // watchdog running
  logic [1:0]     opt;                                        // standby option field
  logic           sel_tick;                                   // tick of the chosen source
  logic           retain_halt;                                // counter frozen in standby
  logic [16:0]    limit;                                      // last count before overflow
  logic           overflow;                                   // counter reached its limit
  logic           sub_lost;                                   // subclock stopped while in use
  logic           wdog_fire;                                  // any watchdog reset cause
  logic           ext_any;                                    // pin or power reset request
  logic           standby_entry;                              // rising edge of standby
  logic           do_write;                                   // address and data both held

  // field decode and watchdog events
  always_comb begin
    run         = st_r.ctrl[RUN_BIT];
    opt         = st_r.ctrl[OPT_HI_BIT:OPT_LO_BIT];
    // select 1 counts the subclock, 0 the low-speed rc
    sel_tick    = st_r.ctrl[CLKSEL_BIT] ? sub_tick : rc_tick;
    retain_halt = standby_active && (opt == OPT_RETAIN);
    // 1024 shifted by the code; code 111 wraps to zero so minus one gives 131071
    limit       = (BASE_COUNT << st_r.ctrl[SEL_HI_BIT:SEL_LO_BIT]) - COUNT_ONE;
    overflow    = run && sel_tick && !retain_halt && (st_r.count == limit);
    // a stopped subclock would silently freeze the count, so treat it as a hang
    sub_lost    = run && st_r.ctrl[CLKSEL_BIT] && (!subclock_oscillator_on || hold_mode);
    wdog_fire   = overflow || sub_lost;
    ext_any     = !external_clear_pin_n || low_voltage_clear;
    standby_entry = standby_active && !st_r.standby_prev;
    do_write    = st_r.aw_have && st_r.w_have && !st_r.bvalid;
  end

  // next-state logic for counter, control register, reset sequencer and bus
  always_comb begin
    st_nxt              = st_r;
    st_nxt.wdog_pulse   = 1'b0;
    st_nxt.standby_prev = standby_active;

    // counting; the freeze keeps the value rather than clearing it
    if (run && sel_tick && !retain_halt) begin
      st_nxt.count = st_r.count + COUNT_ONE;
    end

    // write channel capture, address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata  = s_axi_wdata;
      st_nxt.wstrb  = s_axi_wstrb;
    end

    // register write, one cycle after both halves are held
    if (do_write) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = RESP_OKAY;
      if (st_r.awaddr == CTRL_ADDR) begin
        // locked once running; the write is answered but has no effect
        if (!run && st_r.wstrb[0]) begin
          st_nxt.ctrl = st_r.wdata[7:0];
        end
      end else if (st_r.awaddr == CLEAR_ADDR) begin
        // stands for the immediate move; a plain 55H to control does nothing
        if (run && st_r.wstrb[0] && (st_r.wdata[7:0] == CLEAR_CODE)) begin
          st_nxt.count = COUNT_ZERO;
        end
      end else if (st_r.awaddr != STATUS_ADDR) begin
        st_nxt.bresp = RESP_SLVERR;                           // unmapped address
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // suspend option stops the watchdog on standby entry
    if (standby_entry && run && (opt == OPT_SUSPEND)) begin
      st_nxt.ctrl[RUN_BIT] = 1'b0;
    end

    // watchdog reset keeps clock select, option and overflow fields;
    // applied after the bus write so the set beats a software clear
    if (wdog_fire) begin
      st_nxt.ctrl[FLAG_BIT] = 1'b1;
      st_nxt.ctrl[RUN_BIT]  = 1'b0;
      st_nxt.wdog_pulse     = 1'b1;
    end

    // pin or power reset wins over everything
    if (ext_any) begin
      st_nxt.ctrl = CTRL_RESET;
    end

    // counter never runs on from a stale value
    if (!st_nxt.ctrl[RUN_BIT]) begin
      st_nxt.count = COUNT_ZERO;
    end

    // reset sequencer: stretch every cause to a whole number of aclk cycles
    case (st_r.seq)
      SEQ_RUN: begin
        if (ext_any || wdog_fire) begin
          st_nxt.seq              = SEQ_RESET;
          st_nxt.hold             = HOLD_CYCLES - HOLD_ONE;
          st_nxt.standby_at_reset = standby_active;
          st_nxt.cause_wdog       = !ext_any;
        end
      end
      SEQ_RESET: begin
        if (ext_any || wdog_fire) begin
          // a held pin keeps the chip in reset however long it lasts
          st_nxt.hold = HOLD_CYCLES - HOLD_ONE;
        end else if (st_r.hold != HOLD_ZERO) begin
          st_nxt.hold = st_r.hold - HOLD_ONE;
        end else begin
          st_nxt.seq              = SEQ_RUN;
          st_nxt.standby_at_reset = 1'b0;
        end
      end
      default: begin
        st_nxt.seq = SEQ_RESET;
      end
    endcase

    // read channel; data registered one cycle after the address
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      st_nxt.rdata  = '0;
      if (s_axi_araddr == CTRL_ADDR) begin
        st_nxt.rdata[7:0] = st_r.ctrl;
      end else if (s_axi_araddr == STATUS_ADDR) begin
        st_nxt.rdata[STAT_CNT_LO +: COUNT_W] = st_r.count;
        st_nxt.rdata[STAT_RST_BIT]           = (st_r.seq == SEQ_RESET);
        st_nxt.rdata[STAT_CAUSE_BIT]         = st_r.cause_wdog;
      end else if (s_axi_araddr != CLEAR_ADDR) begin
        st_nxt.rresp = RESP_SLVERR;                           // unmapped address
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // single state register; aresetn is taken as the power-on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus handshakes; one write and one read in flight at most
  always_comb begin
    s_axi_awready = !st_r.aw_have && !st_r.bvalid;
    s_axi_wready  = !st_r.w_have && !st_r.bvalid;
    s_axi_arready = !st_r.rvalid;
    s_axi_bvalid  = st_r.bvalid;
    s_axi_bresp   = st_r.bresp;
    s_axi_rvalid  = st_r.rvalid;
    s_axi_rdata   = st_r.rdata;
    s_axi_rresp   = st_r.rresp;
  end

  // oscillator request: watchdog demand and start bit are or-ed, so a hung
  // system clock cannot stop the rc; retain option drops the demand in standby
  always_comb begin
    slow_rc_enable = (!st_r.ctrl[CLKSEL_BIT] && run && !retain_halt) || slow_rc_start_bit;
  end

  // reset consequences from flip-flops, pc and sp load values constant; ram gets no reset line at all
  always_comb begin
    watchdog_reset          = st_r.wdog_pulse;
    sysrst.reset_n          = (st_r.seq == SEQ_RUN);
    sysrst.medium_rc_select = (st_r.seq == SEQ_RESET);
    sysrst.port_input_mode  = (st_r.seq == SEQ_RESET);
    sysrst.pullup_off       = (st_r.seq == SEQ_RESET);
    sysrst.exit_to_reset    = st_r.standby_at_reset;
    sysrst.pc_init          = PC_RESET;
    sysrst.sp_init          = SP_RESET;
  end

endmodule : wdru_watchdog_reset_unit

/* File: wdru_checker_assertions.sv */
// concurrent checks on the ports of the watchdog reset unit
`timescale 1ns/10ps
module wdru_checker_assertions (
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic                      slow_rc_start_bit,
  input wire logic                      slow_rc_enable,
  input wire logic                      external_clear_pin_n,
  input wire logic                      low_voltage_clear,
  input wire logic                      watchdog_reset,
  input wire wdru_pkg::wdru_sysrst_type sysrst
);
  import wdru_pkg::*;

  // one clock domain, so clock and disable are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // the internal reset is stretched so that chip initialisation completes
  sequence sys_held_low;
    !sysrst.reset_n [*4];
  endsequence
  // and it must come back up, otherwise the chip hangs in reset
  sequence sys_back_up;
    ##[1:20] sysrst.reset_n;
  endsequence

  pulse_one_cycle_a: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset pulse longer than one cycle");
  dog_causes_reset_a: assert property (watchdog_reset |-> ##[0:1] !sysrst.reset_n)
    else $error("watchdog event without system reset");
  // a pin still held low keeps the reset up as long as it lasts, so only short causes are timed
  stretch_bounds_a: assert property ($fell(sysrst.reset_n) && external_clear_pin_n && !low_voltage_clear |->
    sys_held_low ##0 sys_back_up)
    else $error("system reset stretch has the wrong length");
  pin_reset_a: assert property (!external_clear_pin_n || low_voltage_clear |-> ##[0:1] !sysrst.reset_n)
    else $error("pin or power reset did not reach the system reset");
  force_bits_a: assert property (sysrst.port_input_mode == !sysrst.reset_n &&
    sysrst.pullup_off == !sysrst.reset_n && sysrst.medium_rc_select == !sysrst.reset_n)
    else $error("reset-time forcing bits disagree with system reset");
  init_values_a: assert property (sysrst.pc_init == PC_RESET && sysrst.sp_init == SP_RESET)
    else $error("program counter or stack pointer load value not zero");
  rc_start_a: assert property (slow_rc_start_bit |-> slow_rc_enable)
    else $error("rc start bit did not enable the slow rc oscillator");
  write_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while a response is pending");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released after handshake");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released after handshake");
  exit_reset_a: assert property (sysrst.exit_to_reset |-> !sysrst.reset_n)
    else $error("standby exit flag outside a system reset");
endmodule : wdru_checker_assertions

/* File: test_watchdog_reset_unit.sv */
// self-checking bench for the watchdog reset unit
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_watchdog_reset_unit;
  import wdru_pkg::*;
  logic [19:0]     s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata, got, m, e;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, aclk, aresetn;
  logic            rc_tick, sub_tick, subclock_oscillator_on, slow_rc_start_bit, slow_rc_enable;
  logic            standby_active, hold_mode, external_clear_pin_n, low_voltage_clear, watchdog_reset;
  wdru_sysrst_type sysrst;
  logic [31:0]     exp_q[$], msk_q[$];                 // expected answer and compare mask
  int              num_errors, samples_checked, pulses;
  localparam int   PIN_LOW_CYCLES = 20_000;            // 200 us of aclk at 10 ns

  wdru_watchdog_reset_unit dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rc_tick,
    .sub_tick, .subclock_oscillator_on, .slow_rc_start_bit, .slow_rc_enable, .standby_active, .hold_mode,
    .external_clear_pin_n, .low_voltage_clear, .watchdog_reset, .sysrst);

  // free-running system clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // watcher: each bus answer against the oldest note; pre-edge values are what the edge sampled
  always @(posedge aclk) begin
    if (aresetn && watchdog_reset) pulses++;
    if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
      got = s_axi_bvalid ? {30'h0000_0000, s_axi_bresp} : {s_axi_rresp, s_axi_rdata[29:0]};
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK(got & m, e)
    end
  end

  // one write; address and data offered together, each released once taken
  task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge aclk);
    exp_q.push_back({30'h0000_0000, r});
    msk_q.push_back(32'h0000_0003);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) num_errors++;
  endtask : wr

  // one read; the answer is {rresp, rdata[29:0]} under mask mk
  task automatic rd(input logic [19:0] a, input logic [31:0] ex, input logic [31:0] mk);
    int n;
    @(posedge aclk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) num_errors++;
  endtask : rd

  // n slow-clock ticks, one per system cycle, from rc or subclock
  task automatic tick(input int n, input logic sub);
    repeat (n) begin
      @(posedge aclk);
      rc_tick  <= !sub;
      sub_tick <= sub;
    end
    @(posedge aclk);
    rc_tick  <= 1'b0;
    sub_tick <= 1'b0;
  endtask : tick

  // pin reset held for its guaranteed low time, or one-cycle low-voltage reset when lv is set
  task automatic hit_reset(input logic lv);
    @(posedge aclk);
    external_clear_pin_n <= lv;
    low_voltage_clear    <= lv;
    repeat (lv ? 1 : PIN_LOW_CYCLES) @(posedge aclk);
    external_clear_pin_n <= 1'b1;
    low_voltage_clear    <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : hit_reset

  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // hang guard, beyond the roughly 85k cycles the sequence needs
  initial begin
    #950_000;
    num_errors++;
    final_report();
  end

  // main sequence
  initial begin
    logic [1:0] opt;
    logic [7:0] ctl;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
    {rc_tick, sub_tick, slow_rc_start_bit, standby_active, hold_mode, low_voltage_clear} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    subclock_oscillator_on = 1'b1;
    external_clear_pin_n = 1'b1;
    void'($urandom(32'h7ad1));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_ADDR, 32'h0000_0000, 32'hc000_00ff);
    rd(20'h0_0010, 32'h8000_0000, 32'hffff_ffff);
    wr(20'h0_0010, 32'h0000_0000, RESP_SLVERR);
    // counter clear only by the dedicated code, other writes locked out
    wr(CTRL_ADDR, 32'h0000_0020, RESP_OKAY);
    tick(100, 1'b0);
    wr(CLEAR_ADDR, 32'h0000_0054, RESP_OKAY);
    rd(STATUS_ADDR, 32'h0000_0064, 32'h0001_ffff);
    wr(CLEAR_ADDR, {24'h00_0000, CLEAR_CODE}, RESP_OKAY);
    rd(STATUS_ADDR, 32'h0000_0000, 32'h0001_ffff);
    wr(CTRL_ADDR, $urandom & 32'h0000_00df, RESP_OKAY);
    rd(CTRL_ADDR, 32'h0000_0020, 32'hc000_00ff);
    hit_reset(1'b0);
    rd(CTRL_ADDR, 32'h0000_0000, 32'hc000_00ff);
    rd(STATUS_ADDR, 32'h0000_0000, 32'h0001_ffff);
    // overflow at each count, one tick short first; limited to codes that fit the run time
    for (int c = 0; c < 6; c++) begin
      opt = ($urandom % 2) ? 2'b11 : 2'b00;
      ctl = {3'b001, opt, c[2:0]};
      wr(CTRL_ADDR, {24'h00_0000, ctl}, RESP_OKAY);
      tick((1024 << c) - 1, 1'b0);
      rd(STATUS_ADDR, (32'h0000_0400 << c) - 32'h0000_0001, 32'h0001_ffff);
      `CHK(pulses, c)
      tick(1, 1'b0);
      repeat (3) @(posedge aclk);
      `CHK(pulses, c + 1)
      rd(CTRL_ADDR, {24'h00_0000, ctl ^ 8'ha0}, 32'hc000_00ff);
    end
    hit_reset(1'b1);
    rd(CTRL_ADDR, 32'h0000_0000, 32'hc000_00ff);
    // subclock source, then its loss by software and by hold mode
    wr(CTRL_ADDR, 32'h0000_0060, RESP_OKAY);
    tick(5, 1'b1);
    tick(5, 1'b0);
    rd(STATUS_ADDR, 32'h0000_0005, 32'h0001_ffff);
    subclock_oscillator_on <= 1'b0;
    rd(CTRL_ADDR, 32'h0000_00c0, 32'hc000_00ff);
    subclock_oscillator_on <= 1'b1;
    wr(CTRL_ADDR, 32'h0000_0060, RESP_OKAY);
    {hold_mode, standby_active} <= 2'b11;
    rd(CTRL_ADDR, 32'h0000_00c0, 32'hc000_00ff);
    `CHK(sysrst.exit_to_reset, 1'b1)
    {hold_mode, standby_active} <= 2'b00;
    `CHK(pulses, 8)
    // standby suspend stops the watchdog
    wr(CTRL_ADDR, 32'h0000_0028, RESP_OKAY);
    standby_active <= 1'b1;
    repeat (3) @(posedge aclk);
    standby_active <= 1'b0;
    rd(CTRL_ADDR, 32'h0000_0008, 32'hc000_00ff);
    // standby retain freezes the count and parks the rc oscillator
    wr(CTRL_ADDR, 32'h0000_0030, RESP_OKAY);
    tick(10, 1'b0);
    `CHK(slow_rc_enable, 1'b1)
    standby_active <= 1'b1;
    tick(10, 1'b0);
    `CHK(slow_rc_enable, 1'b0)
    slow_rc_start_bit <= 1'b1;
    tick(2, 1'b0);
    `CHK(slow_rc_enable, 1'b1)
    {standby_active, slow_rc_start_bit} <= 2'b00;
    rd(STATUS_ADDR, 32'h0000_000a, 32'h0001_ffff);
    final_report();
  end
endmodule : test_watchdog_reset_unit

bind wdru_watchdog_reset_unit wdru_checker_assertions chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .slow_rc_start_bit, .slow_rc_enable,
  .external_clear_pin_n, .low_voltage_clear, .watchdog_reset, .sysrst);
